// >>> design/itfd_top.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
// Behaviour
// - Fifteen input terminals each carry their own function-select code choosing the command they drive.
// - Select codes reset to 1, 2, 11, 12, 13, 14, 10 for base inputs one to seven and 0 for all others.
// - The three analog inputs act as function terminals only while enabled for digital use.
// - With the expansion card fitted, four more digital inputs become terminals, and one analog input does too while enabled for digital use.
// - A terminal coded 0 has no effect on any command.
// - Code 1 issues run while active, only under terminal command source.
// - Code 2 drives forward/reverse under terminal command source.
// - Code 3 issues stop only under terminal command source with a 3-wire mode (2 or 3).
// - Codes 4 and 5 jog forward and reverse under terminal source; both together ramp to stop.
// - With reverse prohibited the reverse jog is disabled.
// - Code 6 raises and code 7 lowers the frequency offset at the configured rate while active and source A takes part.
// - Code 8 clears the up/down offset to zero.
// - Final source A frequency is set frequency plus offset, only while source A takes part; offset is readable.
// - Code 9 while running blocks output at once so the motor coasts.
// - Code 10 resets a fault like the keypad reset button.
// - Codes 11 to 14 form a four-bit preset speed code; zero defers to source A; unassigned bits read zero.
module itfd_top
  import itfd_pkg::*;
#(
  parameter int TICK_CYCLES = itfd_pkg::OFS_TICK_CYCLES
) (
  input  wire logic                                clk_in,
  input  wire logic                                rst_n_in,
  input  wire logic [10:0]                         digital_terminal_inputs_in,
  input  wire logic [2:0]                          analog_inputs_as_digital_in,
  input  wire logic                                expansion_analog_input_in,
  input  wire logic                                running_in,
  input  wire logic                                fault_in,
  input  wire logic                                psel_in,
  input  wire logic                                penable_in,
  input  wire logic                                pwrite_in,
  input  wire logic [7:0]                          paddr_in,
  input  wire logic [31:0]                         pwdata_in,
  output logic [31:0]                              prdata_out,
  output logic                                     pready_out,
  output logic                                     pslverr_out,
  output logic                                     run_cmd_out,
  output logic                                     fwd_rev_out,
  output logic                                     stop3_out,
  output logic                                     jog_forward_out,
  output logic                                     jog_reverse_out,
  output logic                                     ramp_stop_out,
  output logic                                     coast_stop_out,
  output logic                                     fault_reset_out,
  output logic [3:0]                               preset_speed_sel_out,
  output logic [itfd_pkg::FREQ_W-1:0]              final_freq_a_out
);
  import itfd_pkg::*;

  // The offset prescaler is 16 bits wide, so larger tick counts cannot be served
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_tick_check
    $error("TICK_CYCLES out of range");
  end


  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [NUM_TERM-1:0]             sync1;
    logic [NUM_TERM-1:0]             sync2;
    logic [NUM_TERM-1:0][CODE_W-1:0] fsel;
    logic [1:0]                      cmd_src;
    logic [1:0]                      mode;
    logic [2:0]                      ai_en;
    logic                            ai4_en;
    logic                            exp_fit;
    logic                            no_rev;
    logic                            main_a;
    logic [15:0]                     rate;
    logic [15:0]                     setf;
    logic signed [15:0]              offset;
    logic [15:0]                     tick_cnt;
    logic                            flt_rst_prev;
    logic [31:0]                     prdata;
    logic                            pready;
    logic                            pslverr;
    logic                            run_cmd;
    logic                            fwd_rev;
    logic                            stop3;
    logic                            jog_f;
    logic                            jog_r;
    logic                            ramp_stop;
    logic                            coast;
    logic                            flt_rst;
    logic [3:0]                      preset;
    logic [FREQ_W-1:0]               final_f;
  } itfd_state_s;

  itfd_state_s state_reg;
  itfd_state_s state_next;

  logic [NUM_TERM-1:0]  raw_terms;
  logic [NUM_TERM-1:0]  term_ok;
  logic [NUM_CODES-1:0] act;
  logic                 term_src;
  logic                 tick;
  logic                 wr_en;
  logic [31:0]          ctrl_word;
  logic signed [16:0]   ofs_sum;
  logic signed [17:0]   freq_sum;

  assign raw_terms = {digital_terminal_inputs_in[10:7], expansion_analog_input_in,
                      analog_inputs_as_digital_in, digital_terminal_inputs_in[6:0]};

  always_comb begin
    state_next = state_reg;
    // Only sync1 feeds sync2; decode looks at sync2 alone
    state_next.sync1 = raw_terms;
    state_next.sync2 = state_reg.sync1;

    // Slot qualification for analog and expansion terminals
    term_ok = '1;
    for (int i = 0; i < 3; i++) begin
      term_ok[SLOT_AI_LO + i] = state_reg.ai_en[i];
    end
    term_ok[SLOT_AI4] = state_reg.exp_fit & state_reg.ai4_en;
    for (int i = SLOT_EXP_X; i < NUM_TERM; i++) begin
      term_ok[i] = state_reg.exp_fit;
    end

    act = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (state_reg.sync2[i] && term_ok[i]) begin
        act[state_reg.fsel[i]] = 1'b1;
      end
    end
    act[FN_NONE] = 1'b0;

    term_src = (state_reg.cmd_src == CMD_SRC_TERMINAL);
    state_next.run_cmd = term_src & act[FN_RUN];
    state_next.fwd_rev = term_src & act[FN_FWD_REV];
    state_next.stop3 = term_src & act[FN_STOP3] &
                       (state_reg.mode == MODE_3WIRE_A || state_reg.mode == MODE_3WIRE_B);
    state_next.ramp_stop = term_src & act[FN_JOG_FWD] & act[FN_JOG_REV];
    state_next.jog_f = term_src & act[FN_JOG_FWD] & ~act[FN_JOG_REV];
    // Reverse jog is the one blocked when reverse running is prohibited
    state_next.jog_r = term_src & act[FN_JOG_REV] & ~act[FN_JOG_FWD] & ~state_reg.no_rev;
    state_next.coast = act[FN_COAST] & running_in;
    // One-cycle pulse per press, like a keypad button; only acts on a standing fault
    state_next.flt_rst_prev = act[FN_FLT_RST];
    state_next.flt_rst = act[FN_FLT_RST] & ~state_reg.flt_rst_prev & fault_in;
    for (int b = 0; b < 4; b++) begin
      state_next.preset[b] = act[int'(FN_PRESET0) + b];
    end

    // Offset ramp prescaler
    tick = (state_reg.tick_cnt == TICK_LAST);
    state_next.tick_cnt = tick ? 16'h0000 : state_reg.tick_cnt + 16'h0001;

    ofs_sum = 17'sh00000;
    if (act[FN_OFS_CLR]) begin
      state_next.offset = 16'sh0000;
    end else if (state_reg.main_a && tick && (act[FN_UP] ^ act[FN_DOWN])) begin
      if (act[FN_UP]) begin
        ofs_sum = 17'(state_reg.offset) + signed'({1'b0, state_reg.rate});
      end else begin
        ofs_sum = 17'(state_reg.offset) - signed'({1'b0, state_reg.rate});
      end
      // Saturate instead of wrapping so a held key cannot flip the sign
      if (ofs_sum > 17'sh07FFF) begin
        state_next.offset = 16'sh7FFF;
      end else if (ofs_sum < -17'sh08000) begin
        state_next.offset = -16'sh8000;
      end else begin
        state_next.offset = ofs_sum[15:0];
      end
    end

    freq_sum = signed'({2'b00, state_reg.setf}) + 18'(state_reg.offset);
    if (!state_reg.main_a) begin
      state_next.final_f = state_reg.setf;
    end else if (freq_sum < 18'sh00000) begin
      state_next.final_f = '0;
    end else if (freq_sum > 18'sh0FFFF) begin
      state_next.final_f = '1;
    end else begin
      state_next.final_f = freq_sum[FREQ_W-1:0];
    end

    // APB: setup cycle prepares the answer, access phase shows it with pready high
    ctrl_word = '0;
    ctrl_word[CTRL_SRC_LSB +: 2]  = state_reg.cmd_src;
    ctrl_word[CTRL_MODE_LSB +: 2] = state_reg.mode;
    ctrl_word[CTRL_AI_LSB +: 3]   = state_reg.ai_en;
    ctrl_word[CTRL_AI4_BIT]       = state_reg.ai4_en;
    ctrl_word[CTRL_EXP_BIT]       = state_reg.exp_fit;
    ctrl_word[CTRL_NOREV]         = state_reg.no_rev;
    ctrl_word[CTRL_MAINA]         = state_reg.main_a;
    wr_en = psel_in & penable_in & state_reg.pready & pwrite_in;
    state_next.pready  = psel_in & ~penable_in;
    state_next.pslverr = 1'b0;
    state_next.prdata  = '0;
    if (psel_in && !penable_in) begin
      if (paddr_in <= ADDR_FSEL_LAST && paddr_in[1:0] == 2'b00) begin
        state_next.prdata = 32'(state_reg.fsel[paddr_in[7:2]]);
      end else begin
        case (paddr_in)
          ADDR_CTRL: begin
            state_next.prdata = ctrl_word;
          end
          ADDR_RATE: begin
            state_next.prdata = 32'(state_reg.rate);
          end
          ADDR_STATUS: begin
            state_next.prdata = 32'(state_reg.sync2);
            state_next.prdata[STAT_FAULT] = fault_in;
            state_next.prdata[STAT_RUN] = running_in;
          end
          ADDR_OFFSET: begin
            state_next.prdata = 32'(state_reg.offset);
          end
          ADDR_SETF: begin
            state_next.prdata = 32'(state_reg.setf);
          end
          default: begin
            state_next.pslverr = 1'b1;
          end
        endcase
      end
    end
    if (wr_en && !state_reg.pslverr) begin
      if (paddr_in <= ADDR_FSEL_LAST) begin
        state_next.fsel[paddr_in[7:2]] = pwdata_in[CODE_W-1:0];
      end else begin
        case (paddr_in)
          ADDR_CTRL: begin
            state_next.cmd_src = pwdata_in[CTRL_SRC_LSB +: 2];
            state_next.mode    = pwdata_in[CTRL_MODE_LSB +: 2];
            state_next.ai_en   = pwdata_in[CTRL_AI_LSB +: 3];
            state_next.ai4_en  = pwdata_in[CTRL_AI4_BIT];
            state_next.exp_fit = pwdata_in[CTRL_EXP_BIT];
            state_next.no_rev  = pwdata_in[CTRL_NOREV];
            state_next.main_a  = pwdata_in[CTRL_MAINA];
          end
          ADDR_RATE: begin
            state_next.rate = {1'b0, pwdata_in[14:0]};
          end
          ADDR_SETF: begin
            state_next.setf = pwdata_in[15:0];
          end
          default: begin
            state_next.rate = state_reg.rate;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg         <= '0;
      state_reg.fsel    <= FSEL_RST;
      state_reg.cmd_src <= CMD_SRC_TERMINAL;
      state_reg.main_a  <= 1'b1;
      state_reg.rate    <= RATE_RST;
      state_reg.setf    <= SETF_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata_out           = state_reg.prdata;
  assign pready_out           = state_reg.pready;
  assign pslverr_out          = state_reg.pslverr;
  assign run_cmd_out          = state_reg.run_cmd;
  assign fwd_rev_out          = state_reg.fwd_rev;
  assign stop3_out            = state_reg.stop3;
  assign jog_forward_out      = state_reg.jog_f;
  assign jog_reverse_out      = state_reg.jog_r;
  assign ramp_stop_out        = state_reg.ramp_stop;
  assign coast_stop_out       = state_reg.coast;
  assign fault_reset_out      = state_reg.flt_rst;
  assign preset_speed_sel_out = state_reg.preset;
  assign final_freq_a_out     = state_reg.final_f;
endmodule

// >>> pkg/itfd_pkg.sv
package itfd_pkg;
  localparam int NUM_TERM   = 15;
  localparam int CODE_W     = 5;
  localparam int FREQ_W     = 16;
  // Terminal slot order: 0..6 base, 7..9 analog, 10 expansion analog, 11..14 expansion digital
  localparam int SLOT_AI_LO = 7;
  localparam int SLOT_AI4   = 10;
  localparam int SLOT_EXP_X = 11;

  // Function-select codes
  localparam logic [CODE_W-1:0] FN_NONE     = 5'h00;
  localparam logic [CODE_W-1:0] FN_RUN      = 5'h01;
  localparam logic [CODE_W-1:0] FN_FWD_REV  = 5'h02;
  localparam logic [CODE_W-1:0] FN_STOP3    = 5'h03;
  localparam logic [CODE_W-1:0] FN_JOG_FWD  = 5'h04;
  localparam logic [CODE_W-1:0] FN_JOG_REV  = 5'h05;
  localparam logic [CODE_W-1:0] FN_UP       = 5'h06;
  localparam logic [CODE_W-1:0] FN_DOWN     = 5'h07;
  localparam logic [CODE_W-1:0] FN_OFS_CLR  = 5'h08;
  localparam logic [CODE_W-1:0] FN_COAST    = 5'h09;
  localparam logic [CODE_W-1:0] FN_FLT_RST  = 5'h0A;
  localparam logic [CODE_W-1:0] FN_PRESET0  = 5'h0B;
  localparam int                NUM_CODES   = 32;

  localparam logic [NUM_TERM-1:0][CODE_W-1:0] FSEL_RST = {
    5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
    5'h0A, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h02, 5'h01};

  localparam logic [1:0] CMD_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] MODE_3WIRE_A     = 2'h2;
  localparam logic [1:0] MODE_3WIRE_B     = 2'h3;

  // Register byte addresses
  localparam logic [7:0] ADDR_FSEL_BASE = 8'h00;
  localparam logic [7:0] ADDR_FSEL_LAST = 8'h38;
  localparam logic [7:0] ADDR_CTRL      = 8'h40;
  localparam logic [7:0] ADDR_RATE      = 8'h44;
  localparam logic [7:0] ADDR_STATUS    = 8'h48;
  localparam logic [7:0] ADDR_OFFSET    = 8'h4C;
  localparam logic [7:0] ADDR_SETF      = 8'h50;

  // CTRL and STATUS fields
  localparam int CTRL_SRC_LSB  = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_AI_LSB   = 4;
  localparam int CTRL_AI4_BIT  = 7;
  localparam int CTRL_EXP_BIT  = 8;
  localparam int CTRL_NOREV    = 9;
  localparam int CTRL_MAINA    = 10;
  localparam int STAT_FAULT    = 16;
  localparam int STAT_RUN      = 17;

  localparam logic [15:0] RATE_RST = 16'h0001;
  localparam logic [15:0] SETF_RST = 16'h0000;

  localparam int OFS_TICK_US     = 1000;
  localparam int CLK_MHZ         = 50;
  localparam int OFS_TICK_CYCLES = OFS_TICK_US * CLK_MHZ;
endpackage

// >>> dv/itfd_switches.sv
`timescale 1ns/100ps
module itfd_switches
  import itfd_pkg::*;
(
  input  wire logic [NUM_TERM-1:0] level_in,
  input  wire logic                clk_in,
  output logic      [10:0]         digital_terminal_inputs_out,
  output logic      [2:0]          analog_inputs_as_digital_out,
  output logic                     expansion_analog_input_out
);
  // Contacts move on a clock edge only; bounce is not modelled
  always @(posedge clk_in) begin
    digital_terminal_inputs_out  <= {level_in[14:11], level_in[6:0]};
    analog_inputs_as_digital_out <= level_in[9:7];
    expansion_analog_input_out   <= level_in[SLOT_AI4];
  end
endmodule

// >>> dv/itfd_asserts.sv
`timescale 1ns/100ps
module itfd_asserts (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic running_in,
  input wire logic fault_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic run_cmd_out,
  input wire logic jog_forward_out,
  input wire logic jog_reverse_out,
  input wire logic ramp_stop_out,
  input wire logic coast_stop_out,
  input wire logic fault_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_access; psel_in && penable_in && pready_out; endsequence
  chk_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no ready in access cycle");
  chk_ready_one_cycle: assert property (s_access |=> !pready_out)
    else $error("ready held too long");
  chk_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  chk_both_jogs_ramp: assert property (ramp_stop_out |-> !jog_forward_out && !jog_reverse_out)
    else $error("jog with ramp stop");
  chk_coast_when_running: assert property (coast_stop_out |-> $past(running_in))
    else $error("coast while not running");
  chk_fault_reset_pulse: assert property (fault_reset_out |=> !fault_reset_out)
    else $error("fault reset longer than a cycle");
  chk_fault_reset_gated: assert property (fault_reset_out |-> $past(fault_in))
    else $error("fault reset without fault");
  chk_reset_quiet: assert property ($rose(rst_n_in) |-> !run_cmd_out && !coast_stop_out)
    else $error("command active after reset");
endmodule
bind itfd_top itfd_asserts chk_u (
  .clk_in, .rst_n_in, .psel_in, .penable_in, .running_in, .fault_in, .pready_out,
  .pslverr_out, .run_cmd_out, .jog_forward_out, .jog_reverse_out, .ramp_stop_out,
  .coast_stop_out, .fault_reset_out);

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import itfd_pkg::*;
  logic              clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic              running_in, fault_in, expansion_analog_input_in, err, seen;
  logic [7:0]        paddr_in;
  logic [31:0]       pwdata_in, prdata_out, rd, ofs;
  logic [10:0]       digital_terminal_inputs_in;
  logic [2:0]        analog_inputs_as_digital_in;
  logic [14:0]       level;
  logic              run_cmd_out, fwd_rev_out, stop3_out, jog_forward_out, jog_reverse_out;
  logic              ramp_stop_out, coast_stop_out, fault_reset_out;
  logic [3:0]        preset_speed_sel_out;
  logic [FREQ_W-1:0] final_freq_a_out;
  int                fails = 0;
  int                compares = 0;
  int                cycles = 0;
  // Short tick keeps the offset ramp test to a few dozen cycles
  itfd_top #(.TICK_CYCLES(4)) dut_u (
    .clk_in, .rst_n_in, .digital_terminal_inputs_in, .analog_inputs_as_digital_in,
    .expansion_analog_input_in, .running_in, .fault_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .run_cmd_out, .fwd_rev_out,
    .stop3_out, .jog_forward_out, .jog_reverse_out, .ramp_stop_out, .coast_stop_out,
    .fault_reset_out, .preset_speed_sel_out, .final_freq_a_out);
  itfd_switches sw_u (.level_in(level), .clk_in, .digital_terminal_inputs_out(digital_terminal_inputs_in),
    .analog_inputs_as_digital_out(analog_inputs_as_digital_in),
    .expansion_analog_input_out(expansion_analog_input_in));
  task automatic chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd  = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Pin to output is three edges; one more for the switch model
  task automatic pins(input logic [14:0] v);
    @(posedge clk_in);
    level <= v;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic t_regs();
    byte dflt[7] = '{8'h01, 8'h02, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0A};
    for (int s = 0; s < NUM_TERM; s++) begin
      apb(1'b0, 8'(4 * s), 32'h00000000);
      chk("fsel", rd, s < 7 ? 32'(dflt[s]) : 32'h00000000);
    end
    apb(1'b0, ADDR_CTRL, 32'h00000000);
    chk("ctrl", rd, 32'h00000401);
    wr(8'h54, 32'hFFFFFFFF);
    chk("slverr", 32'(err), 32'h00000001);
    $display("test regs done");
  endtask
  task automatic t_run();
    pins(15'h0001);
    chk("run", 32'(run_cmd_out), 32'h00000001);
    pins(15'h0003);
    chk("fwd_rev", 32'(fwd_rev_out), 32'h00000001);
    wr(ADDR_CTRL, 32'h00000400);
    pins(15'h0003);
    chk("run_src", 32'(run_cmd_out), 32'h00000000);
    wr(ADDR_CTRL, 32'h00000401);
    wr(ADDR_FSEL_BASE, 32'h00000000);
    pins(15'h0001);
    chk("code0", 32'(run_cmd_out), 32'h00000000);
    wr(ADDR_FSEL_BASE, 32'h00000001);
    wr(8'h04, 32'h00000001);
    pins(15'h0002);
    chk("shared", 32'(run_cmd_out), 32'h00000001);
    $display("test run done");
  endtask
  task automatic t_jog();
    wr(ADDR_FSEL_BASE, 32'h00000004);
    wr(8'h04, 32'h00000005);
    pins(15'h0001);
    chk("jog_f", 32'(jog_forward_out), 32'h00000001);
    pins(15'h0002);
    chk("jog_r", 32'(jog_reverse_out), 32'h00000001);
    pins(15'h0003);
    chk("ramp", 32'({ramp_stop_out, jog_forward_out, jog_reverse_out}), 32'h00000004);
    wr(ADDR_CTRL, 32'h00000601);
    pins(15'h0002);
    chk("no_rev", 32'(jog_reverse_out), 32'h00000000);
    wr(ADDR_FSEL_BASE, 32'h00000003);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, 32'h00000401 | 32'(m << 2));
      pins(15'h0001);
      chk("stop3", 32'(stop3_out), 32'(m >= 2));
    end
    $display("test jog done");
  endtask
  task automatic t_preset();
    wr(ADDR_FSEL_BASE, 32'h00000000);
    wr(8'h04, 32'h00000000);
    wr(8'h1C, 32'h0000000E);
    wr(8'h2C, 32'h0000000C);
    wr(8'h28, 32'h0000000B);
    pins(15'h0014);
    chk("preset", 32'(preset_speed_sel_out), 32'h00000005);
    pins(15'h0C80);
    chk("ai_off", 32'(preset_speed_sel_out), 32'h00000000);
    wr(ADDR_CTRL, 32'h00000411);
    pins(15'h0C80);
    chk("ai_on", 32'(preset_speed_sel_out), 32'h00000008);
    wr(ADDR_CTRL, 32'h00000591);
    pins(15'h0C80);
    chk("exp", 32'(preset_speed_sel_out), 32'h0000000B);
    $display("test preset done");
  endtask
  task automatic t_offset();
    wr(ADDR_CTRL, 32'h00000401);
    wr(ADDR_FSEL_BASE, 32'h00000006);
    wr(8'h04, 32'h00000007);
    wr(8'h08, 32'h00000008);
    wr(ADDR_RATE, 32'h00000005);
    wr(ADDR_SETF, 32'h00000064);
    pins(15'h0001);
    repeat (40) @(posedge clk_in);
    pins(15'h0000);
    apb(1'b0, ADDR_OFFSET, 32'h00000000);
    ofs = rd;
    chk("ofs_step", ofs % 5, 32'h00000000);
    chk("ofs_up", 32'($signed(ofs) > 0), 32'h00000001);
    chk("final", 32'(final_freq_a_out), ofs + 32'h00000064);
    pins(15'h0002);
    pins(15'h0000);
    apb(1'b0, ADDR_OFFSET, 32'h00000000);
    chk("ofs_down", 32'($signed(rd) < $signed(ofs)), 32'h00000001);
    ofs = rd;
    // Offset is still nonzero here, so leaving source A must hide it and freeze it
    wr(ADDR_CTRL, 32'h00000001);
    pins(15'h0001);
    repeat (20) @(posedge clk_in);
    pins(15'h0000);
    chk("main_off", 32'(final_freq_a_out), 32'h00000064);
    apb(1'b0, ADDR_OFFSET, 32'h00000000);
    chk("ofs_hold", rd, ofs);
    wr(ADDR_CTRL, 32'h00000401);
    pins(15'h0004);
    apb(1'b0, ADDR_OFFSET, 32'h00000000);
    chk("ofs_clr", rd, 32'h00000000);
    $display("test offset done");
  endtask
  task automatic t_stops();
    wr(ADDR_FSEL_BASE, 32'h00000009);
    pins(15'h0001);
    chk("coast_idle", 32'(coast_stop_out), 32'h00000000);
    @(posedge clk_in);
    running_in <= 1'b1;
    pins(15'h0001);
    chk("coast", 32'(coast_stop_out), 32'h00000001);
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_in);
      fault_in <= f[0];
      pins(15'h0000);
      @(posedge clk_in);
      level <= 15'h0040;
      seen = 1'b0;
      repeat (8) @(posedge clk_in) seen = seen | (fault_reset_out === 1'b1);
      chk("fault_reset", 32'(seen), 32'(f));
    end
    apb(1'b0, ADDR_STATUS, 32'h00000000);
    chk("status", rd, 32'h00030040);
    $display("test stops done");
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n_in, psel_in, penable_in, pwrite_in, running_in, fault_in} = 6'h00;
    paddr_in  = 8'h00;
    pwdata_in = 32'h00000000;
    level     = 15'h0000;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_run();
    t_jog();
    t_preset();
    t_offset();
    t_stops();
    tally_and_finish();
  end
endmodule
